// ===== rtl/dds_core_pkg.sv
`default_nettype none
package dds_core_pkg;
   localparam int ACC_W = 48;
   localparam int PHASE_W = 14;
   localparam int SAMPLE_W = 14;
   localparam int SCALE_W = 10;
   localparam int LUT_ADDR_W = 8;
   // Default scale code for 20 mA with the recommended reference resistor:
   // 120 uA * (72 + 192*code/1024) lands nearest 20 mA at code 0x1F9
   localparam logic [9:0] SCALE_RST = 10'h1F9;
   localparam logic [47:0] TUNE_RST = 48'h000000000000;
   localparam logic [13:0] PHASE_RST = 14'h0000;
   // Power-up reset pulse
   localparam int CLK_MHZ = 25;
   localparam int POR_US = 10;
   localparam int POR_CYCLES = POR_US * CLK_MHZ;
   // Register indices on the control port
   localparam logic [3:0] REG_TUNE_LO = 4'h0;
   localparam logic [3:0] REG_TUNE_MID = 4'h1;
   localparam logic [3:0] REG_TUNE_HI = 4'h2;
   localparam logic [3:0] REG_PHASE = 4'h3;
   localparam logic [3:0] REG_SCALE = 4'h4;
   localparam logic [3:0] REG_STATUS = 4'h5;
   localparam logic [3:0] REG_PHASE_NOW = 4'h6;

   typedef struct packed {
      logic [47:0] tuning_increment;
      logic [13:0] phase_offset;
      logic [9:0] dac_current_scale_code;
   } ctrl_words_t;

   typedef struct packed {
      logic [3:0] addr;
      logic [15:0] wdata;
      logic wr;
      logic rd;
   } reg_req_t;
endpackage
`default_nettype wire

// ===== rtl/sine_lookup.sv
`default_nettype none
// Quarter-wave sine table with quadrant folding, one cycle latency
module sine_lookup #(
   parameter int PHASE_W = 14,
   parameter int SAMPLE_W = 14,
   parameter int LUT_ADDR_W = 8
)(
   input wire logic clock,
   input wire logic sys_rst,
   input wire logic [PHASE_W-1:0] phase,
   output logic [SAMPLE_W-1:0] sample_q
);
   localparam int N = 1 << LUT_ADDR_W;
   localparam real PI = 3.14159265358979;
   localparam int AMP = (1 << (SAMPLE_W - 1)) - 1;

   logic [SAMPLE_W-2:0] table_q [N];
   logic [LUT_ADDR_W-1:0] addr;
   logic [LUT_ADDR_W-1:0] frac;
   logic [SAMPLE_W-2:0] mag;

   // Table built at elaboration; constant contents, no memory file
   initial
   begin
      for (int i = 0; i < N; i++)
      begin
         table_q[i] = (SAMPLE_W-1)'($rtoi(AMP * $sin(PI / 2.0 *
            (real'(i) + 0.5) / real'(N)) + 0.5));
      end
   end

   assign frac = phase[PHASE_W-3 -: LUT_ADDR_W];
   assign addr = phase[PHASE_W-2] ? ~frac : frac;
   assign mag = table_q[addr];

   always_ff @(posedge clock)
   begin
      if (sys_rst)
         sample_q <= '0;
      else if (phase[PHASE_W-1])
         sample_q <= SAMPLE_W'(0) - {1'b0, mag};
      else
         sample_q <= {1'b0, mag};
   end
endmodule
`default_nettype wire

// ===== rtl/dds_phase_accumulator_core.sv
// Added by the designer: the address-and-strobe port and the register addresses.
`default_nettype none
// Overview of operation
// - Every clock adds tuning increment to phase accumulator, modulo 2^48.
// - Overflow wraps keeping the remainder, never clears to zero.
// - Tuning increment is 48-bit unsigned and alone sets accumulator step.
// - A 14-bit phase offset spans one full cycle over 2^14 codes.
// - Offset phase becomes one sinusoid sample per clock for the DAC.
// - Sample words to the converter are 14 bits wide.
// - A 10-bit full-scale code is held and driven to DAC scaling.
// - After reset the scale code gives 20 mA full scale.
// - Update strobe rising edge copies staging words into active words.
// - Chip reset input resets; power-up also makes a 10 us reset.
module dds_phase_accumulator_core #(
   parameter int POR_LEN = dds_core_pkg::POR_CYCLES
)(
   input wire logic clock,
   input wire logic sys_rst,
   input wire logic io_update,
   input wire logic [3:0] reg_addr,
   input wire logic [15:0] reg_wdata,
   input wire logic reg_wr,
   input wire logic reg_rd,
   output logic [15:0] reg_rdata_q,
   output logic [dds_core_pkg::SAMPLE_W-1:0] dac_sample_q,
   output logic [dds_core_pkg::SCALE_W-1:0] dac_current_scale_code,
   output logic in_reset
);
   ////////////////////////////////////////////////////////////////////
   // Reset: pin or internal power-up pulse
   logic [15:0] por_cnt_q = '0;
   logic por_done_q = 1'b0;
   logic rst;

   // Initial values model power-on state; counter then runs out
   always_ff @(posedge clock)
   begin
      if (!por_done_q)
      begin
         por_cnt_q <= por_cnt_q + 16'h0001;
         por_done_q <= (por_cnt_q == 16'(POR_LEN - 1));
      end
   end

   // Reset pin comes from off chip: two stages before any logic reads it
   logic rst_meta_q;
   logic rst_sync_q;

   always_ff @(posedge clock)
   begin
      rst_meta_q <= sys_rst;
      rst_sync_q <= rst_meta_q;
   end

   // A pin pulse shorter than one clock may be missed
   assign rst = rst_sync_q | ~por_done_q;
   assign in_reset = rst;

   ////////////////////////////////////////////////////////////////////
   // Update strobe synchroniser and edge detect
   logic upd_meta_q;
   logic upd_sync_q;
   logic upd_prev_q;
   logic upd_rise;

   always_ff @(posedge clock)
   begin
      if (rst)
      begin
         upd_meta_q <= 1'b0;
         upd_sync_q <= 1'b0;
         upd_prev_q <= 1'b0;
      end
      else
      begin
         upd_meta_q <= io_update;
         upd_sync_q <= upd_meta_q;
         upd_prev_q <= upd_sync_q;
      end
   end

   assign upd_rise = upd_sync_q & ~upd_prev_q;

   ////////////////////////////////////////////////////////////////////
   // Staging and active control words
   dds_core_pkg::ctrl_words_t stage_q;
   dds_core_pkg::ctrl_words_t active_q;

   // Staging words after one write; read-only and unmapped indices drop it
   function automatic dds_core_pkg::ctrl_words_t write_word(
      input logic [3:0] idx,
      input logic [15:0] data,
      input dds_core_pkg::ctrl_words_t staged
   );
      write_word = staged;
      case (idx)
         dds_core_pkg::REG_TUNE_LO:
            write_word.tuning_increment[15:0] = data;
         dds_core_pkg::REG_TUNE_MID:
            write_word.tuning_increment[31:16] = data;
         dds_core_pkg::REG_TUNE_HI:
            write_word.tuning_increment[47:32] = data;
         dds_core_pkg::REG_PHASE:
            write_word.phase_offset = data[13:0];
         dds_core_pkg::REG_SCALE:
            write_word.dac_current_scale_code = data[9:0];
         default:
            write_word = staged;
      endcase
   endfunction

   always_ff @(posedge clock)
   begin
      if (rst)
      begin
         stage_q.tuning_increment <= dds_core_pkg::TUNE_RST;
         stage_q.phase_offset <= dds_core_pkg::PHASE_RST;
         stage_q.dac_current_scale_code <= dds_core_pkg::SCALE_RST;
      end
      else if (reg_wr)
         stage_q <= write_word(reg_addr, reg_wdata, stage_q);
   end

   // Staged values stay dormant until the strobe edge
   always_ff @(posedge clock)
   begin
      if (rst)
      begin
         active_q.tuning_increment <= dds_core_pkg::TUNE_RST;
         active_q.phase_offset <= dds_core_pkg::PHASE_RST;
         active_q.dac_current_scale_code <= dds_core_pkg::SCALE_RST;
      end
      else if (upd_rise)
         active_q <= stage_q;
   end

   assign dac_current_scale_code = active_q.dac_current_scale_code;

   ////////////////////////////////////////////////////////////////////
   // Phase accumulator
   logic [dds_core_pkg::ACC_W-1:0] acc_q;
   logic [dds_core_pkg::PHASE_W-1:0] phase_q;

   // Unsigned add truncated to 48 bits keeps the wrap remainder
   always_ff @(posedge clock)
   begin
      if (rst)
         acc_q <= '0;
      else
         acc_q <= acc_q + active_q.tuning_increment;
   end

   // Offset only touches the derived phase, never acc_q
   function automatic logic [dds_core_pkg::PHASE_W-1:0] offset_phase(
      input logic [dds_core_pkg::ACC_W-1:0] acc,
      input logic [dds_core_pkg::PHASE_W-1:0] offset
   );
      // Modulo add: a full turn of offset lands on the same phase
      offset_phase = acc[dds_core_pkg::ACC_W-1 -: dds_core_pkg::PHASE_W]
         + offset;
   endfunction

   always_ff @(posedge clock)
   begin
      if (rst)
         phase_q <= '0;
      else
         phase_q <= offset_phase(acc_q, active_q.phase_offset);
   end

   ////////////////////////////////////////////////////////////////////
   // Phase to amplitude
   sine_lookup #(
      .PHASE_W(dds_core_pkg::PHASE_W),
      .SAMPLE_W(dds_core_pkg::SAMPLE_W),
      .LUT_ADDR_W(dds_core_pkg::LUT_ADDR_W)
   ) u_sine (
      .clock(clock),
      .sys_rst(rst),
      .phase(phase_q),
      .sample_q(dac_sample_q)
   );

   ////////////////////////////////////////////////////////////////////
   // Register read port

   // Read-back word of one index; unmapped indices read as zero
   function automatic logic [15:0] read_word(
      input logic [3:0] idx,
      input dds_core_pkg::ctrl_words_t staged,
      input dds_core_pkg::ctrl_words_t live,
      input logic [dds_core_pkg::PHASE_W-1:0] phase
   );
      case (idx)
         dds_core_pkg::REG_TUNE_LO:
            read_word = staged.tuning_increment[15:0];
         dds_core_pkg::REG_TUNE_MID:
            read_word = staged.tuning_increment[31:16];
         dds_core_pkg::REG_TUNE_HI:
            read_word = staged.tuning_increment[47:32];
         dds_core_pkg::REG_PHASE:
            read_word = {2'b00, staged.phase_offset};
         dds_core_pkg::REG_SCALE:
            read_word = {6'h00, staged.dac_current_scale_code};
         dds_core_pkg::REG_STATUS:
            read_word = {6'h00, live.dac_current_scale_code};
         dds_core_pkg::REG_PHASE_NOW:
            read_word = {2'b00, phase};
         default:
            read_word = 16'h0000;
      endcase
   endfunction

   always_ff @(posedge clock)
   begin
      if (rst)
         reg_rdata_q <= '0;
      else if (reg_rd)
         reg_rdata_q <= read_word(reg_addr, stage_q, active_q, phase_q);
      else
         reg_rdata_q <= 16'h0000;
   end
endmodule
`default_nettype wire

// ===== bench/dds_core_properties.sv
`default_nettype none
module dds_core_properties (
   input wire logic clock,
   input wire logic sys_rst,
   input wire logic io_update,
   input wire logic [3:0] reg_addr,
   input wire logic reg_rd,
   input wire logic [15:0] reg_rdata_q,
   input wire logic [13:0] dac_sample_q,
   input wire logic [9:0] dac_current_scale_code,
   input wire logic in_reset
);
   timeunit 1ns;
   timeprecision 1ps;
   default clocking @(posedge clock); endclocking
   default disable iff (sys_rst);
   wire logic rd_ok = reg_rd && !in_reset;
   property p_rst_rd; $fell(sys_rst) |-> reg_rdata_q == 16'h0000; endproperty
   a_rst_rd: assert property (p_rst_rd) else $error("rdata in reset");
   property p_rst_smp; $fell(sys_rst) |-> dac_sample_q == 14'h0000; endproperty
   a_rst_smp: assert property (p_rst_smp) else $error("sample in reset");
   property p_exit; $fell(sys_rst) |-> ##[0:2] !in_reset; endproperty
   a_exit: assert property (p_exit) else $error("stuck in reset");
   property p_idle; !$past(reg_rd) |-> reg_rdata_q == 16'h0000; endproperty
   a_idle: assert property (p_idle) else $error("read data stands");
   // Sync stages flushed after six quiet cycles
   property p_hold; (!io_update && !in_reset) [*6]
      |=> $stable(dac_current_scale_code); endproperty
   a_hold: assert property (p_hold) else $error("scale moved");
   property p_stat; rd_ok && reg_addr == dds_core_pkg::REG_STATUS
      |=> reg_rdata_q == {6'h00, $past(dac_current_scale_code)}; endproperty
   a_stat: assert property (p_stat) else $error("status read");
   property p_unmap; rd_ok && reg_addr > dds_core_pkg::REG_PHASE_NOW
      |=> reg_rdata_q == 16'h0000; endproperty
   a_unmap: assert property (p_unmap) else $error("unmapped read");
   property p_amp; !in_reset |-> dac_sample_q != 14'h2000; endproperty
   a_amp: assert property (p_amp) else $error("sample range");
   c_stat: cover property (rd_ok && reg_addr == dds_core_pkg::REG_STATUS);
   c_upd: cover property ($changed(dac_current_scale_code) && !in_reset);
   c_neg: cover property (dac_sample_q[13]);
endmodule
`default_nettype wire

// ===== bench/dac_model.sv
`default_nettype none
module dac_model (
   input wire logic clock,
   input wire logic [13:0] sample,
   input wire logic [9:0] scale_code,
   output var int full_scale_ua,
   output var int out_ua
);
   timeunit 1ns;
   timeprecision 1ps;
   // Reference fixed at 120 uA; integer truncation
   always_comb
      full_scale_ua = 120 * (73728 + 192 * int'(scale_code)) / 1024;
   always_ff @(posedge clock)
      out_ua <= full_scale_ua * int'($signed(sample)) / 16384;
endmodule
`default_nettype wire

// ===== bench/tb.sv
`default_nettype none
module tb;
   timeunit 1ns;
   timeprecision 1ps;
   logic clock = 1'b0, sys_rst = 1'b1, io_update = 1'b0;
   logic reg_wr = 1'b0, reg_rd = 1'b0, in_reset;
   logic [3:0] reg_addr = 4'h0;
   logic [15:0] reg_wdata = 16'h0000, reg_rdata_q, v, w;
   logic [13:0] dac_sample_q;
   logic [9:0] dac_current_scale_code;
   logic [63:0] tv [4] = '{64'h6664000000003332, 64'h0004000000000002,
      64'h0003FFFFFFFF0002, 64'h0000000000000000};
   int fs_ua, out_ua, fails = 0, compares = 0;
   always #20 clock = ~clock;
   dds_phase_accumulator_core #(.POR_LEN(4)) i_dds_phase_accumulator_core (
      .clock(clock), .sys_rst(sys_rst), .io_update(io_update),
      .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
      .reg_rd(reg_rd), .reg_rdata_q(reg_rdata_q), .in_reset(in_reset),
      .dac_sample_q(dac_sample_q),
      .dac_current_scale_code(dac_current_scale_code));
   dac_model i_dac_model (.clock(clock), .sample(dac_sample_q),
      .scale_code(dac_current_scale_code), .full_scale_ua(fs_ua),
      .out_ua(out_ua));
   task automatic wr(input logic [3:0] a, input logic [15:0] d);
      @(posedge clock);
      reg_wr <= 1'b1;
      reg_addr <= a;
      reg_wdata <= d;
      @(posedge clock);
      reg_wr <= 1'b0;
   endtask
   task automatic rd(input logic [3:0] a, output logic [15:0] d);
      @(posedge clock);
      reg_rd <= 1'b1;
      reg_addr <= a;
      @(posedge clock);
      reg_rd <= 1'b0;
      #1 d = reg_rdata_q;
   endtask
   // Pulse spans the two sync stages, then lets the pipe drain
   task automatic upd;
      @(posedge clock);
      io_update <= 1'b1;
      repeat (3) @(posedge clock);
      io_update <= 1'b0;
      repeat (4) @(posedge clock);
      #1;
   endtask
   task automatic chk(input string n, input logic [15:0] e, g);
      compares++;
      if (g !== e)
      begin
         fails++;
         $display("BAD %s expected %h seen %h", n, e, g);
      end
   endtask
   task automatic give_verdict;
      $display("compares %0d fails %0d", compares, fails);
      if (fails == 0 && compares > 0)
         $display("[ PASS ]");
      else
         $display("[ FAIL ]");
      $finish;
   endtask
   initial
   begin
      repeat (12) @(posedge clock);
      sys_rst <= 1'b0;
      #1 chk("sample", 16'h0000, {2'b00, dac_sample_q});
      chk("fs", 16'h0001, {15'h0, fs_ua >= 19975 && fs_ua <= 20025});
      for (int i = 0; i < 20 && in_reset !== 1'b0; i++)
      begin
         @(posedge clock);
         #1;
      end
      if (in_reset !== 1'b0)
      begin
         fails++;
         give_verdict;
      end
      $display("test reset done");
      wr(dds_core_pkg::REG_PHASE, 16'h1000);
      upd;
      v = {15'h0, !dac_sample_q[13] && dac_sample_q > 14'h1FC0};
      chk("peak", 16'h0001, v);
      wr(dds_core_pkg::REG_PHASE, 16'h3000);
      upd;
      v = {15'h0, dac_sample_q > 14'h2000 && dac_sample_q < 14'h2040};
      chk("trough", 16'h0001, v);
      chk("dac sign", 16'h0001, {15'h0, out_ua < 0});
      $display("test offset done");
      rd(dds_core_pkg::REG_STATUS, v);
      chk("status rst", {6'h00, dds_core_pkg::SCALE_RST}, v);
      wr(dds_core_pkg::REG_SCALE, 16'h03FF);
      repeat (8) @(posedge clock);
      rd(dds_core_pkg::REG_STATUS, w);
      chk("held", {6'h00, dds_core_pkg::SCALE_RST}, w);
      rd(dds_core_pkg::REG_SCALE, w);
      chk("staged", 16'h03FF, w);
      upd;
      chk("scale", 16'h03FF, {6'h00, dac_current_scale_code});
      chk("fs max", 16'h7BA9, fs_ua[15:0]);
      wr(dds_core_pkg::REG_STATUS, 16'h0000);
      rd(dds_core_pkg::REG_STATUS, w);
      chk("status", 16'h03FF, w);
      rd(4'hF, w);
      chk("unmapped", 16'h0000, w);
      $display("test scale done");
      for (int i = 0; i < 4; i++)
      begin
         wr(dds_core_pkg::REG_TUNE_HI, tv[i][63:48]);
         wr(dds_core_pkg::REG_TUNE_MID, tv[i][47:32]);
         wr(dds_core_pkg::REG_TUNE_LO, tv[i][31:16]);
         upd;
         rd(dds_core_pkg::REG_PHASE_NOW, v);
         rd(dds_core_pkg::REG_PHASE_NOW, w);
         chk("step", tv[i][15:0], (w - v) & 16'h3FFF);
      end
      $display("test step done");
      give_verdict;
   end
endmodule
bind dds_phase_accumulator_core dds_core_properties i_dds_core_properties (
   .clock(clock), .sys_rst(sys_rst), .io_update(io_update),
   .reg_addr(reg_addr), .reg_rd(reg_rd), .reg_rdata_q(reg_rdata_q),
   .dac_sample_q(dac_sample_q), .in_reset(in_reset),
   .dac_current_scale_code(dac_current_scale_code));
`default_nettype wire
